/* design/vpi_pkg.sv */
package vpi_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_SOURCES = 40;
   localparam int NUM_VECTORS = 10;
   localparam int VEC_IDX_W   = 4;
   localparam int ADDR_W      = 20;
   localparam int STACK_DEPTH = 4;

   // ------------------------------------------------------------
   // Vector addresses
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] VEC_BASE_ADDR = 20'h00003;
   localparam logic [ADDR_W-1:0] VEC_STEP      = 20'h00008;

   // ------------------------------------------------------------
   // Levels, highest above high above low
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_NONE    = 2'b00,
      LVL_LOW     = 2'b01,
      LVL_HIGH    = 2'b10,
      LVL_HIGHEST = 2'b11
   } level_t;

   localparam logic [NUM_VECTORS-1:0] LEVEL_SEL_RESET = 10'h000;

   // ------------------------------------------------------------
   // Source bit positions within the 40-bit request vector
   // ------------------------------------------------------------
   localparam int SRC_V1_LO  = 0;   // ext_pin_irq_a
   localparam int SRC_V1_HI  = 0;
   localparam int SRC_V2_LO  = 1;   // ext_pin_irq_b
   localparam int SRC_V2_HI  = 1;
   localparam int SRC_V3_LO  = 2;   // pin c, timer0 low, pin e, usb bus active, remote
   localparam int SRC_V3_HI  = 6;
   localparam int SRC_V4_LO  = 7;   // pin d, pin f, base timer
   localparam int SRC_V4_HI  = 9;
   localparam int SRC_V5_LO  = 10;  // timer_zero_high_event, pin g, usb connect/disc/resume
   localparam int SRC_V5_HI  = 14;
   localparam int SRC_V6_LO  = 15;  // timer one low/high, pin h, serial_channel_d, audio start
   localparam int SRC_V6_HI  = 19;
   localparam int SRC_V7_LO  = 20;  // serial a, uart rx
   localparam int SRC_V7_HI  = 21;
   localparam int SRC_V8_LO  = 22;  // serial b, serial c, uart tx, audio end
   localparam int SRC_V8_HI  = 25;
   localparam int SRC_V9_LO  = 26;  // converter, timer6, timer7, usb ack/nak/err/stall
   localparam int SRC_V9_HI  = 32;
   localparam int SRC_V10_LO = 33;  // port0, pwm0, pwm1, timer4, timer5, usb sof, copy done
   localparam int SRC_V10_HI = 39;

endpackage

/* design/vpi_level_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module vpi_level_stack
   import vpi_pkg::*;
#(
   parameter int DEPTH = vpi_pkg::STACK_DEPTH
) (
   input  wire logic          clk_in,     // System clock
   input  wire logic          reset_in,   // Sync reset, active high
   input  wire logic          push_in,    // Push a level
   input  wire vpi_pkg::level_t push_lvl_in, // Level pushed
   input  wire logic          pop_in,     // Restore previous level
   output vpi_pkg::level_t    top_out     // Current in-service level
);
   import vpi_pkg::*;

   level_t stk_q [DEPTH];
   level_t stk_d [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         stk_d[i] = stk_q[i];
      end
      if (push_in) begin
         stk_d[0] = push_lvl_in;
         for (int i = 1; i < DEPTH; i++) begin
            stk_d[i] = stk_q[i-1];
         end
      end else if (pop_in) begin
         for (int i = 0; i < DEPTH-1; i++) begin
            stk_d[i] = stk_q[i+1];
         end
         stk_d[DEPTH-1] = LVL_NONE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            stk_q[i] <= LVL_NONE;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            stk_q[i] <= stk_d[i];
         end
      end
   end

   assign top_out = stk_q[0];
endmodule
`default_nettype wire

/* design/vectored_priority_interrupt.sv */
// Overview of operation
// - Three nested levels highest>high>low; current in-service level is tracked.
// - Requests at or below the in-service level stay pending, not accepted.
// - Among simultaneous different vectors, the highest level wins.
// - Among equal levels, the smallest vector address wins.
// - Forty sources ORed onto ten vectors.
// - Vector 1 at 00003H, pin a, level highest or low only.
// - Vector 2 at 0000BH, pin b, level highest or low only.
// - Vectors 3-10 at 00013H..0004BH step eight, high or low only.
// - Vector 00023H merges timer0 high, pin g, usb connect/disconnect/resume.
// - Vector 0002BH merges timer1 halves, pin h, serial d, audio start.
// - Vector 00043H merges converter, timers 6/7, usb ack/nak/error/stall.
// - Vector 0004BH merges port0, pwms, timers 4/5, usb sof, copy done.
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupt
   import vpi_pkg::*;
#(
   parameter int DEPTH = vpi_pkg::STACK_DEPTH
) (
   input  wire logic                   clk_in,        // System clock
   input  wire logic                   reset_in,      // Sync reset, active high
   input  wire logic [NUM_SOURCES-1:0] src_req_in,    // Source request levels
   input  wire logic [NUM_VECTORS-1:0] level_sel_in,  // 1 = upper level per vector
   input  wire logic                   ack_in,        // Core accepts request
   input  wire logic                   reti_in,       // Core returns from service
   output logic                        irq_out,       // Request to core
   output logic [ADDR_W-1:0]           vec_addr_out,  // Offered vector address
   output logic [VEC_IDX_W-1:0]        vec_num_out,   // Offered vector number 1..10
   output vpi_pkg::level_t             cur_level_out, // In-service level
   output logic [NUM_VECTORS-1:0]      vec_pend_out   // Merged pending per vector
);
   import vpi_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic level_t vec_level(input int v, input logic upper);
      if (!upper) begin
         vec_level = LVL_LOW;
      end else if (v < 2) begin
         vec_level = LVL_HIGHEST;
      end else begin
         vec_level = LVL_HIGH;
      end
   endfunction

   function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_IDX_W-1:0] v);
      vec_addr = VEC_BASE_ADDR + ADDR_W'(v) * VEC_STEP;
   endfunction

   // Lowest source bit of a vector
   function automatic int src_lo(input int v);
      if (v == 0) begin
         src_lo = SRC_V1_LO;
      end else if (v == 1) begin
         src_lo = SRC_V2_LO;
      end else if (v == 2) begin
         src_lo = SRC_V3_LO;
      end else if (v == 3) begin
         src_lo = SRC_V4_LO;
      end else if (v == 4) begin
         src_lo = SRC_V5_LO;
      end else if (v == 5) begin
         src_lo = SRC_V6_LO;
      end else if (v == 6) begin
         src_lo = SRC_V7_LO;
      end else if (v == 7) begin
         src_lo = SRC_V8_LO;
      end else if (v == 8) begin
         src_lo = SRC_V9_LO;
      end else begin
         src_lo = SRC_V10_LO;
      end
   endfunction

   // Highest source bit of a vector
   function automatic int src_hi(input int v);
      if (v == 0) begin
         src_hi = SRC_V1_HI;
      end else if (v == 1) begin
         src_hi = SRC_V2_HI;
      end else if (v == 2) begin
         src_hi = SRC_V3_HI;
      end else if (v == 3) begin
         src_hi = SRC_V4_HI;
      end else if (v == 4) begin
         src_hi = SRC_V5_HI;
      end else if (v == 5) begin
         src_hi = SRC_V6_HI;
      end else if (v == 6) begin
         src_hi = SRC_V7_HI;
      end else if (v == 7) begin
         src_hi = SRC_V8_HI;
      end else if (v == 8) begin
         src_hi = SRC_V9_HI;
      end else begin
         src_hi = SRC_V10_HI;
      end
   endfunction

   // Mask of the sources that share a vector
   function automatic logic [NUM_SOURCES-1:0] src_mask(input int v);
      src_mask = '0;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         if (i >= src_lo(v) && i <= src_hi(v)) begin
            src_mask[i] = 1'b1;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Source merge
   // ------------------------------------------------------------
   logic [NUM_VECTORS-1:0] vreq;
   for (genvar g = 0; g < NUM_VECTORS; g++) begin : g_merge
      assign vreq[g] = |(src_req_in & src_mask(g));
   end

   // ------------------------------------------------------------
   // Per-vector level
   // ------------------------------------------------------------
   level_t vlvl [NUM_VECTORS];
   for (genvar g = 0; g < NUM_VECTORS; g++) begin : g_level
      assign vlvl[g] = vec_level(g, level_sel_in[g]);
   end

   // ------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------
   level_t                 cur_lvl;
   level_t                 win_lvl;
   logic [VEC_IDX_W-1:0]   win_idx;
   logic                   win_ok;

   always_comb begin
      win_lvl = LVL_NONE;
      win_idx = '0;
      win_ok  = 1'b0;
      // Descending scan, greater-or-equal ties favour smaller index
      for (int v = NUM_VECTORS-1; v >= 0; v--) begin
         if (vreq[v] && vlvl[v] >= win_lvl && vlvl[v] > cur_lvl) begin
            win_lvl = vlvl[v];
            win_idx = VEC_IDX_W'(v);
            win_ok  = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Offer registers
   // ------------------------------------------------------------
   logic                   irq_q, irq_d;
   logic [VEC_IDX_W-1:0]   num_q, num_d;
   logic [ADDR_W-1:0]      addr_q, addr_d;
   level_t                 lvl_q, lvl_d;
   logic [NUM_VECTORS-1:0] pend_q;
   logic                   accept;

   // Accept only a still-valid registered offer
   assign accept = ack_in && irq_q;

   always_comb begin
      irq_d  = win_ok && !accept && !reti_in;
      num_d  = win_idx + 4'h1;
      addr_d = vec_addr(win_idx);
      lvl_d  = win_lvl;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         irq_q  <= 1'b0;
         num_q  <= 4'h1;
         addr_q <= VEC_BASE_ADDR;
         lvl_q  <= LVL_NONE;
         pend_q <= '0;
      end else begin
         irq_q  <= irq_d;
         num_q  <= num_d;
         addr_q <= addr_d;
         lvl_q  <= lvl_d;
         pend_q <= vreq;
      end
   end

   // ------------------------------------------------------------
   // In-service level stack
   // ------------------------------------------------------------
   vpi_level_stack #(
      .DEPTH (DEPTH)
   ) u_stack (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .push_in     (accept),
      .push_lvl_in (lvl_q),
      .pop_in      (reti_in),
      .top_out     (cur_lvl)
   );

   level_t cur_q, cur_d;
   always_comb begin
      cur_d = cur_lvl;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cur_q <= LVL_NONE;
      end else begin
         cur_q <= cur_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all registered
   // ------------------------------------------------------------
   assign irq_out       = irq_q;
   assign vec_num_out   = num_q;
   assign vec_addr_out  = addr_q;
   assign cur_level_out = cur_q;
   assign vec_pend_out  = pend_q;
endmodule
`default_nettype wire

/* bench/vpi_checker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module vpi_checker
   import vpi_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic                   clk_in,        // Clock
   input wire logic                   reset_in,      // Reset
   input wire logic [NUM_SOURCES-1:0] src_req_in,    // Sources
   input wire logic [NUM_VECTORS-1:0] level_sel_in,  // Levels
   input wire logic                   ack_in,        // Accept
   input wire logic                   reti_in,       // Return
   input wire logic                   irq_out,       // Offer
   input wire logic [ADDR_W-1:0]      vec_addr_out,  // Address
   input wire logic [VEC_IDX_W-1:0]   vec_num_out,   // Number
   input wire vpi_pkg::level_t        cur_level_out, // Level
   input wire logic [NUM_VECTORS-1:0] vec_pend_out   // Pending
);
   // ---
   // Properties
   // ---
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   function automatic level_t lv(logic [9:0] s, logic [3:0] n);
      return !s[n-1] ? LVL_LOW : (n < 4'h3 ? LVL_HIGHEST : LVL_HIGH);
   endfunction
   property p_rst; $fell(reset_in) |-> !irq_out && cur_level_out == LVL_NONE; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_addr; vec_addr_out == VEC_BASE_ADDR + VEC_STEP * (vec_num_out - 1); endproperty
   a_addr: assert property (p_addr) else $error("vector address wrong");
   property p_v5; !$past(reset_in) |-> vec_pend_out[4] == |$past(src_req_in[14:10]); endproperty
   a_v5: assert property (p_v5) else $error("vector 5 merge wrong");
   property p_v6; !$past(reset_in) |-> vec_pend_out[5] == |$past(src_req_in[19:15]); endproperty
   a_v6: assert property (p_v6) else $error("vector 6 merge wrong");
   property p_v9; !$past(reset_in) |-> vec_pend_out[8] == |$past(src_req_in[32:26]); endproperty
   a_v9: assert property (p_v9) else $error("vector 9 merge wrong");
   property p_v10; !$past(reset_in) |-> vec_pend_out[9] == |$past(src_req_in[39:33]); endproperty
   a_v10: assert property (p_v10) else $error("vector 10 merge wrong");
   property p_lvl; irq_out |-> lv($past(level_sel_in), vec_num_out) > cur_level_out; endproperty
   a_lvl: assert property (p_lvl) else $error("offer not above level");
   property p_push; ack_in && irq_out |-> ##2
      cur_level_out == lv($past(level_sel_in, 3), $past(vec_num_out, 2)); endproperty
   a_push: assert property (p_push) else $error("level not pushed");
   property p_pop; reti_in && !ack_in |-> ##2 cur_level_out < $past(cur_level_out, 2); endproperty
   a_pop: assert property (p_pop) else $error("level not restored");
   c_ack: cover property (ack_in && irq_out);
   c_top: cover property (cur_level_out == LVL_HIGHEST);
   c_ret: cover property (reti_in);
endmodule
bind vectored_priority_interrupt vpi_checker #(.DEPTH(DEPTH)) u_vpi_checker (
   .clk_in(clk_in), .reset_in(reset_in), .src_req_in(src_req_in), .level_sel_in(level_sel_in),
   .ack_in(ack_in), .reti_in(reti_in), .irq_out(irq_out), .vec_addr_out(vec_addr_out),
   .vec_num_out(vec_num_out), .cur_level_out(cur_level_out), .vec_pend_out(vec_pend_out));
`default_nettype wire

/* bench/cpu_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
   input  wire logic       clk_in,       // Clock
   input  wire logic       irq_in,       // Offer
   input  wire logic [3:0] vec_num_in,   // Offered vector
   input  wire logic       accept_en_in, // May accept
   input  wire logic [3:0] delay_in,     // Extra wait
   output var  logic       ack_out,      // Accept pulse
   output var  logic       reti_out,     // Return pulse
   output var  logic [3:0] taken_out     // Accepted vector
);
   logic ret_req = 1'b0;
   int   wait_n  = 0;
   initial begin
      ack_out = 1'b0;
      reti_out = 1'b0;
      taken_out = 4'h0;
   end
   // ---
   // Accept only a standing offer
   // ---
   always @(posedge clk_in) begin
      ack_out <= irq_in && accept_en_in && !ack_out && !ret_req && wait_n >= delay_in;
      reti_out <= ret_req;
      ret_req = 1'b0;
      wait_n <= (irq_in && !ack_out) ? wait_n + 1 : 0;
      if (ack_out) taken_out <= vec_num_in;
   end
   task automatic do_return();
      ret_req = 1'b1;
   endtask
endmodule
`default_nettype wire

/* bench/vectored_priority_interrupt_test.sv */
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupt_test;
   import vpi_pkg::*;
   logic                   clk_in = 0, reset_in = 1, acc = 0, ack, reti, irq;
   logic [NUM_SOURCES-1:0] src = '0;
   logic [NUM_VECTORS-1:0] sel = '0, pend;
   logic [3:0]             dly = '0, num, took;
   logic [ADDR_W-1:0]      addr;
   level_t                 cur;
   int                     err_count = 0, tests_run = 0;
   int                     hi[10] = '{0, 1, 6, 9, 14, 19, 21, 25, 32, 39};
   vectored_priority_interrupt #(.DEPTH(4)) u_vectored_priority_interrupt (
      .clk_in(clk_in), .reset_in(reset_in), .src_req_in(src), .level_sel_in(sel),
      .ack_in(ack), .reti_in(reti), .irq_out(irq), .vec_addr_out(addr),
      .vec_num_out(num), .cur_level_out(cur), .vec_pend_out(pend));
   cpu_core_model u_cpu_core_model (.clk_in(clk_in), .irq_in(irq), .vec_num_in(num),
      .accept_en_in(acc), .delay_in(dly), .ack_out(ack), .reti_out(reti), .taken_out(took));
   always #50 clk_in = ~clk_in;
   // ---
   // Helpers
   // ---
   task step(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   function automatic int vof(int i);
      for (int k = 0; k < 10; k++)
         if (i <= hi[k]) return k + 1;
      return 0;
   endfunction
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task take(logic [39:0] s, logic [9:0] v, logic [3:0] n, level_t l);
      int t;
      t = 0;
      src = s;
      sel = v;
      acc = 1;
      do @(posedge clk_in);
      while (ack !== 1'b1 && ++t < 20);
      #1;
      acc = 0;
      chk("vector", took, n);
      for (int i = 0; i < 40; i++) if (vof(i) == n) src[i] = 1'b0;
      step(2);
      chk("level", cur, l);
   endtask
   task ret(level_t l);
      u_cpu_core_model.do_return();
      step(4);
      chk("restored", cur, l);
   endtask
   task prio(logic [9:0] v, logic [3:0] n, level_t l);
      take('1, v, n, l);
      src = '0;
      ret(LVL_NONE);
   endtask
   // ---
   // Scenarios
   // ---
   initial begin
      step(6);
      reset_in = 0;
      step(1);
      chk("reset", {irq, cur, addr}, 23'h3);
      for (int i = 0; i < 40; i++) begin
         src = 40'h1 << i;
         step(2);
         chk("merge", pend, 10'h1 << (vof(i) - 1));
         chk("address", addr, 20'h3 + 20'h8 * (vof(i) - 1));
      end
      prio(10'h020, 6, LVL_HIGH);
      prio(10'h000, 1, LVL_LOW);
      prio(10'h006, 2, LVL_HIGHEST);
      prio(10'h3FC, 3, LVL_HIGH);
      prio(10'h001, 1, LVL_HIGHEST);
      take(40'h80, 0, 4, LVL_LOW);
      src = 40'h4;
      step(6);
      chk("refused", irq, 0);
      take(40'h404, 10'h010, 5, LVL_HIGH);
      src[15] = 1;
      sel = 10'h030;
      step(6);
      chk("refused", irq, 0);
      dly = 3;
      take(src | 40'h1, 10'h031, 1, LVL_HIGHEST);
      ret(LVL_HIGH);
      chk("refused", irq, 0);
      ret(LVL_LOW);
      chk("reoffer", num, 6);
      src = '0;
      ret(LVL_NONE);
      tally_and_finish;
   end
   initial begin
      #3000000;
      err_count++;
      tally_and_finish;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
endmodule
`default_nettype wire
